// ---- shared/rate_match_params.svh ----
// rate_match_params.svh: register offsets, field positions, reset values and sizes
// assumes: included by bare name from the package, ddc_rate_match and the bench files
`ifndef RATE_MATCH_PARAMS_SVH
`define RATE_MATCH_PARAMS_SVH

// ************************************************************
// register word indices; the byte address on the bus is 4 * index
// ************************************************************
`define RM_IDX_LINK_RATE_DIVISOR 12'h0289
`define RM_IDX_JOINT_RETUNE 12'h028A
`define RM_IDX_SIDE_BITS_SEL 12'h02A1
`define RM_IDX_PAGE_SELECT 12'h0300
`define RM_IDX_CHAN_TOTAL_DIV0 12'h0310
`define RM_IDX_CHAN_LINK_MAP 12'h0320
`define RM_IDX_FINE_BYPASS 12'h0321
`define RM_IDX_COARSE_DIV0 12'h0330
`define RM_IDX_CHAN_STATUS 12'h0340
`define RM_IDX_HOP_CONTROL 12'h0341

// ************************************************************
// fields and reset values
// ************************************************************
`define RM_JOINT_RETUNE_BIT 0
`define RM_BIT1_SRC_MSB 7
`define RM_BIT1_SRC_LSB 4
`define RM_BIT0_SRC_MSB 3
`define RM_BIT0_SRC_LSB 0
`define RM_PROFILE_CHAN_MSB 5
`define RM_PROFILE_CHAN_LSB 4
`define RM_RESET_BYTE 8'h00

// ************************************************************
// control bit source codes
// ************************************************************
`define RM_SRC_OVERRANGE 4'h0
`define RM_SRC_ZERO 4'h1
`define RM_SRC_LEVEL_WATCH 4'h2
`define RM_SRC_FAST_THRESH 4'h3
`define RM_SRC_SYSREF 4'h5
`define RM_SRC_NCO_SEL0 4'h8
`define RM_SRC_NCO_SEL1 4'h9
`define RM_SRC_NCO_SEL2 4'hA
`define RM_SRC_NCO_SEL3 4'hB

// ************************************************************
// sizes
// ************************************************************
`define RM_NUM_CHAN 4
`define RM_NUM_LINK 2
`define RM_SAMPLE_W 16
`define RM_FIFO_DEPTH 8

`endif

// ---- shared/rate_match_pkg.sv ----
// rate_match_pkg: types shared by the rate matcher and its bench
// assumes: rate_match_params.svh on the include path
`default_nettype none
`include "rate_match_params.svh"

package rate_match_pkg;

  // one link word: sample, its two side bits and its channel
  typedef struct packed {
    logic [1:0] chan;
    logic side1;
    logic side0;
    logic [`RM_SAMPLE_W-1:0] sample;
  } link_word_t;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_WRITE = 2'b01,
    BUS_READ = 2'b10
  } bus_state_t;

endpackage : rate_match_pkg

`default_nettype wire

// ---- hw/rate_match_fifo.sv ----
// rate_match_fifo: synchronous fifo with valid/ready on both sides
// assumes: single clock, synchronous active-low reset
`timescale 1ns/1ps
`default_nettype none

module rate_match_fifo #(
  parameter int WIDTH = 20,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  // fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [AW:0] cnt_q, cnt_d;
  logic push, pop;

  assign in_ready_o = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid_o = (cnt_q != '0);
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  assign out_data_o = mem_q[rd_q];

  always_comb begin
    wr_d = push ? AW'(wr_q + 1'b1) : wr_q;
    rd_d = pop ? AW'(rd_q + 1'b1) : rd_q;
    cnt_d = cnt_q;
    if (push && !pop) begin
      cnt_d = (AW+1)'(cnt_q + 1'b1);
    end else if (pop && !push) begin
      cnt_d = (AW+1)'(cnt_q - 1'b1);
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
    end
  end

  // storage carries no reset; contents are qualified by the count
  always_ff @(posedge ref_clk_i) begin
    if (push) begin
      mem_q[wr_q] <= in_data_i;
    end
  end

endmodule : rate_match_fifo

`default_nettype wire

// ---- hw/ddc_rate_match.sv ----
// ddc_rate_match: per-link sample rate matching, hop routing and side bit selection
// assumes: AHB-Lite single word transfers, one clock, decimators upstream give a
// one-cycle valid per output sample, transmitter downstream may stall via ready
//
// Implementation choice: register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "rate_match_params.svh"

module ddc_rate_match (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [13:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // downconverter samples
  input wire logic [`RM_NUM_CHAN-1:0] chan_valid_i,
  input wire logic [`RM_NUM_CHAN*`RM_SAMPLE_W-1:0] chan_data_i,
  input wire logic [`RM_NUM_CHAN-1:0] overrange_i,
  input wire logic [`RM_NUM_CHAN-1:0] level_watch_flag_i,
  input wire logic [`RM_NUM_CHAN-1:0] fast_threshold_flag_i,
  // pins
  input wire logic sysref_i,
  input wire logic [5:0] profile_sel_i,
  input wire logic hop_strobe_i,
  // hop outputs to coarse oscillators
  output logic [`RM_NUM_CHAN-1:0] coarse_retune_o,
  output logic [3:0] nco_chan_sel_o,
  // serial link transmitter streams, one per link
  output logic [`RM_NUM_LINK-1:0] link_valid_o,
  input wire logic [`RM_NUM_LINK-1:0] link_ready_i,
  output rate_match_pkg::link_word_t link_word0_o,
  output rate_match_pkg::link_word_t link_word1_o,
  // stall back to decimators, per link
  output logic [`RM_NUM_LINK-1:0] link_accept_o
);

  localparam int NC = `RM_NUM_CHAN;
  localparam int SW = `RM_SAMPLE_W;

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  logic [7:0] pin_s1_q, pin_s2_q, pin_s3_q;
  logic sysref_s, hop_pulse;
  logic [5:0] profile_s;

  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      pin_s1_q <= 8'h00;
      pin_s2_q <= 8'h00;
      pin_s3_q <= 8'h00;
    end else begin
      pin_s1_q <= {hop_strobe_i, sysref_i, profile_sel_i};
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end

  assign profile_s = pin_s2_q[5:0];
  assign sysref_s = pin_s2_q[6];
  assign hop_pulse = pin_s2_q[7] && !pin_s3_q[7];

  // ************************************************************
  // register file
  // ************************************************************
  logic [7:0] divisor_q [`RM_NUM_LINK];
  logic [7:0] total_div_q [NC];
  logic [7:0] coarse_div_q [NC];
  logic [7:0] page_q, link_map_q, bypass_q, joint_q, side_sel_q, hop_ctl_q;
  logic [7:0] status_q;
  rate_match_pkg::bus_state_t bus_q, bus_d;
  logic [11:0] idx_q, idx_d;
  logic [31:0] rdata_q, rdata_d;
  logic [11:0] idx_now;

  assign idx_now = haddr[13:2];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_q;

  always_comb begin
    bus_d = rate_match_pkg::BUS_IDLE;
    idx_d = idx_q;
    if (hsel && hready && htrans[1]) begin
      bus_d = hwrite ? rate_match_pkg::BUS_WRITE : rate_match_pkg::BUS_READ;
      idx_d = idx_now;
    end
  end

  // reads answer in the data phase with zero wait states
  always_comb begin
    rdata_d = 32'h0000_0000;
    case (idx_now)
      `RM_IDX_LINK_RATE_DIVISOR: rdata_d[7:0] = divisor_q[page_q[0]];
      `RM_IDX_JOINT_RETUNE: rdata_d[0] = joint_q[0];
      `RM_IDX_SIDE_BITS_SEL: rdata_d[7:0] = side_sel_q;
      `RM_IDX_PAGE_SELECT: rdata_d[0] = page_q[0];
      `RM_IDX_CHAN_LINK_MAP: rdata_d[7:0] = link_map_q;
      `RM_IDX_FINE_BYPASS: rdata_d[7:0] = bypass_q;
      `RM_IDX_CHAN_STATUS: rdata_d[7:0] = status_q;
      `RM_IDX_HOP_CONTROL: rdata_d[0] = hop_ctl_q[0];
      default: begin
        if (idx_now[11:2] == `RM_IDX_CHAN_TOTAL_DIV0 >> 2) begin
          rdata_d[7:0] = total_div_q[idx_now[1:0]];
        end else if (idx_now[11:2] == `RM_IDX_COARSE_DIV0 >> 2) begin
          rdata_d[7:0] = coarse_div_q[idx_now[1:0]];
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      bus_q <= rate_match_pkg::BUS_IDLE;
      idx_q <= 12'h000;
      rdata_q <= 32'h0000_0000;
    end else begin
      bus_q <= bus_d;
      idx_q <= idx_d;
      if (bus_d == rate_match_pkg::BUS_READ) begin
        rdata_q <= rdata_d;
      end
    end
  end

  logic wr_en;
  assign wr_en = (bus_q == rate_match_pkg::BUS_WRITE);

  // written values are stored as plain binary decimation counts
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      for (int l = 0; l < `RM_NUM_LINK; l++) begin
        divisor_q[l] <= `RM_RESET_BYTE;
      end
      for (int c = 0; c < NC; c++) begin
        total_div_q[c] <= `RM_RESET_BYTE;
        coarse_div_q[c] <= `RM_RESET_BYTE;
      end
      page_q <= `RM_RESET_BYTE;
      link_map_q <= `RM_RESET_BYTE;
      bypass_q <= `RM_RESET_BYTE;
      joint_q <= `RM_RESET_BYTE;
      side_sel_q <= `RM_RESET_BYTE;
      hop_ctl_q <= `RM_RESET_BYTE;
    end else if (wr_en) begin
      case (idx_q)
        `RM_IDX_LINK_RATE_DIVISOR: divisor_q[page_q[0]] <= hwdata[7:0];
        `RM_IDX_JOINT_RETUNE: joint_q <= {7'h00, hwdata[0]};
        `RM_IDX_SIDE_BITS_SEL: side_sel_q <= hwdata[7:0];
        `RM_IDX_PAGE_SELECT: page_q <= {7'h00, hwdata[0]};
        `RM_IDX_CHAN_LINK_MAP: link_map_q <= hwdata[7:0];
        `RM_IDX_FINE_BYPASS: bypass_q <= hwdata[7:0];
        `RM_IDX_HOP_CONTROL: hop_ctl_q <= {7'h00, hwdata[0]};
        default: begin
          if (idx_q[11:2] == `RM_IDX_CHAN_TOTAL_DIV0 >> 2) begin
            total_div_q[idx_q[1:0]] <= hwdata[7:0];
          end else if (idx_q[11:2] == `RM_IDX_COARSE_DIV0 >> 2) begin
            coarse_div_q[idx_q[1:0]] <= hwdata[7:0];
          end
        end
      endcase
    end
  end

  // ************************************************************
  // side bit source multiplexers
  // ************************************************************
  function automatic logic side_pick(input logic [3:0] code, input logic ovr, input logic lvl,
                                     input logic fst, input logic sref, input logic [3:0] nco);
    logic v;
    v = 1'b0;
    case (code)
      `RM_SRC_OVERRANGE: v = ovr;
      `RM_SRC_ZERO: v = 1'b0;
      `RM_SRC_LEVEL_WATCH: v = lvl;
      `RM_SRC_FAST_THRESH: v = fst;
      `RM_SRC_SYSREF: v = sref;
      `RM_SRC_NCO_SEL0: v = nco[0];
      `RM_SRC_NCO_SEL1: v = nco[1];
      `RM_SRC_NCO_SEL2: v = nco[2];
      `RM_SRC_NCO_SEL3: v = nco[3];
      default: v = 1'b0; // reserved codes give zero
    endcase
    return v;
  endfunction : side_pick

  // ************************************************************
  // hop routing
  // ************************************************************
  logic [NC-1:0] retune_d, retune_q;
  logic [3:0] nco_sel_d, nco_sel_q;

  always_comb begin
    retune_d = '0;
    nco_sel_d = nco_sel_q;
    if (hop_ctl_q[0] && hop_pulse) begin
      nco_sel_d = profile_s[3:0];
      if (joint_q[`RM_JOINT_RETUNE_BIT]) begin
        retune_d = '1;
      end else begin
        retune_d[profile_s[`RM_PROFILE_CHAN_MSB:`RM_PROFILE_CHAN_LSB]] = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      retune_q <= '0;
      nco_sel_q <= 4'h0;
    end else begin
      retune_q <= retune_d;
      nco_sel_q <= nco_sel_d;
    end
  end

  assign coarse_retune_o = retune_q;
  assign nco_chan_sel_o = nco_sel_q;

  // ************************************************************
  // per-channel repeaters and link arbitration
  // ************************************************************
  // each channel holds the sample it accepted while idle and emits it ratio times per input
  // sample, where ratio = chan_dec / link_div; a zero or non-divisible ratio
  // falls back to pass-through so an unprogrammed link never stalls
  logic [7:0] chan_dec [NC];
  logic [7:0] ratio [NC];
  logic [7:0] rep_q [NC], rep_d [NC];
  logic [SW-1:0] hold_q [NC], hold_d [NC];
  logic [NC-1:0] pend_q, pend_d, grant;
  logic [`RM_NUM_LINK-1:0] fifo_in_ready, fifo_in_valid;
  rate_match_pkg::link_word_t fifo_in [`RM_NUM_LINK];
  rate_match_pkg::link_word_t fifo_out [`RM_NUM_LINK];

  genvar g;
  generate
    for (g = 0; g < NC; g++) begin : g_chan
      logic lnk;
      assign lnk = link_map_q[g];
      // bypassed fine stage: only the coarse factor counts
      assign chan_dec[g] = bypass_q[g] ? coarse_div_q[g] : total_div_q[g];
      assign ratio[g] = (divisor_q[lnk] != 8'h00 && chan_dec[g] >= divisor_q[lnk] &&
                         (chan_dec[g] % divisor_q[lnk]) == 8'h00) ?
                        8'(chan_dec[g] / divisor_q[lnk]) : 8'h01;
    end
  endgenerate

  always_comb begin
    grant = '0;
    for (int l = 0; l < `RM_NUM_LINK; l++) begin
      fifo_in_valid[l] = 1'b0;
      fifo_in[l] = '0;
      for (int c = NC - 1; c >= 0; c--) begin
        if (pend_q[c] && link_map_q[c] == l[0] && fifo_in_ready[l]) begin
          fifo_in_valid[l] = 1'b1;
          fifo_in[l].chan = 2'(c);
          fifo_in[l].sample = hold_q[c];
          fifo_in[l].side1 = side_pick(side_sel_q[`RM_BIT1_SRC_MSB:`RM_BIT1_SRC_LSB], overrange_i[c],
                                       level_watch_flag_i[c], fast_threshold_flag_i[c], sysref_s,
                                       nco_sel_q);
          fifo_in[l].side0 = side_pick(side_sel_q[`RM_BIT0_SRC_MSB:`RM_BIT0_SRC_LSB], overrange_i[c],
                                       level_watch_flag_i[c], fast_threshold_flag_i[c], sysref_s,
                                       nco_sel_q);
        end
      end
      for (int c = 0; c < NC; c++) begin
        if (fifo_in_valid[l] && fifo_in[l].chan == 2'(c)) begin
          grant[c] = 1'b1;
        end
      end
    end
  end

  always_comb begin
    for (int c = 0; c < NC; c++) begin
      rep_d[c] = rep_q[c];
      hold_d[c] = hold_q[c];
      pend_d[c] = pend_q[c];
      if (grant[c]) begin
        if (rep_q[c] > 8'h01) begin
          rep_d[c] = 8'(rep_q[c] - 1'b1);
        end else begin
          rep_d[c] = 8'h00;
          pend_d[c] = 1'b0; // last repeat sent: channel free again
        end
      end
      if (chan_valid_i[c] && !pend_d[c]) begin
        hold_d[c] = chan_data_i[c*SW +: SW];
        rep_d[c] = ratio[c];
        pend_d[c] = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      pend_q <= '0;
      for (int c = 0; c < NC; c++) begin
        rep_q[c] <= 8'h00;
        hold_q[c] <= '0;
      end
    end else begin
      pend_q <= pend_d;
      for (int c = 0; c < NC; c++) begin
        rep_q[c] <= rep_d[c];
        hold_q[c] <= hold_d[c];
      end
    end
  end

  // a new sample on a busy channel is dropped; the stall only reflects link fifo space, not a busy channel
  assign link_accept_o = fifo_in_ready;

  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      status_q <= 8'h00;
    end else begin
      status_q <= {fifo_in_ready, 2'b00, pend_q};
    end
  end

  // ************************************************************
  // link fifos
  // ************************************************************
  generate
    for (g = 0; g < `RM_NUM_LINK; g++) begin : g_link
      rate_match_fifo #(
        .WIDTH($bits(rate_match_pkg::link_word_t)),
        .DEPTH(`RM_FIFO_DEPTH)
      ) u_fifo (
        .ref_clk_i(ref_clk_i),
        .reset_n_i(reset_n_i),
        .in_valid_i(fifo_in_valid[g]),
        .in_ready_o(fifo_in_ready[g]),
        .in_data_i(fifo_in[g]),
        .out_valid_o(link_valid_o[g]),
        .out_ready_i(link_ready_i[g]),
        .out_data_o(fifo_out[g])
      );
    end
  endgenerate

  assign link_word0_o = fifo_out[0];
  assign link_word1_o = fifo_out[1];

endmodule : ddc_rate_match

`default_nettype wire

// ---- tb/link_sink_model.sv ----
// link_sink_model: stand-in for one serial link transmitter lane
// assumes: bench clock, words are taken on valid and ready
`timescale 1ns/1ps
`default_nettype none
module link_sink_model (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  // pace: stall holds ready low, slow offers ready every other cycle
  input wire logic stall_i,
  input wire logic slow_i,
  // stream
  input wire logic valid_i,
  input wire rate_match_pkg::link_word_t word_i,
  output logic ready_o
);
  rate_match_pkg::link_word_t got_q[$];
  logic tick_q = 1'b0;
  always @(posedge ref_clk_i) begin
    if (reset_n_i && valid_i && ready_o) begin
      got_q.push_back(word_i);
    end
    tick_q <= !tick_q;
    ready_o <= reset_n_i && !stall_i && (!slow_i || tick_q);
  end
endmodule : link_sink_model
`default_nettype wire

// ---- tb/ddc_rate_match_sva.sv ----
// ddc_rate_match_sva: port checks of the rate matcher
// assumes: bound into ddc_rate_match, one clock, sync active-low reset
`timescale 1ns/1ps
`default_nettype none
`include "rate_match_params.svh"
module ddc_rate_match_sva (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  // bus
  input wire logic hsel,
  input wire logic [13:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  // stream and hop
  input wire logic [1:0] link_valid_o,
  input wire logic [1:0] link_ready_i,
  input wire logic [1:0] link_accept_o,
  input wire rate_match_pkg::link_word_t link_word0_o,
  input wire rate_match_pkg::link_word_t link_word1_o,
  input wire logic [3:0] coarse_retune_o,
  input wire logic [3:0] nco_chan_sel_o
);
  // shadow of the side bit source field, lands with the write data
  logic hit_q, hit_d;
  logic [7:0] sel_q, sel_d;
  always_comb begin
    hit_d = hsel && hready && htrans[1] && hwrite && (haddr[13:2] == `RM_IDX_SIDE_BITS_SEL);
    sel_d = hit_q ? hwdata[7:0] : sel_q;
  end
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      hit_q <= 1'b0;
      sel_q <= 8'h00;
    end else begin
      hit_q <= hit_d;
      sel_q <= sel_d;
    end
  end
  // limitation: valid only while the code is changed with the fifo empty
  function automatic logic is_zero(input logic [3:0] c);
    return c == 4'h1 || c == 4'h4 || c == 4'h6 || c == 4'h7;
  endfunction : is_zero
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);
  property p_reset_clear;
    $rose(reset_n_i) |-> link_valid_o == 2'h0 && coarse_retune_o == 4'h0 && nco_chan_sel_o == 4'h0;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("state not clear after reset");
  property p_retune_shape;
    coarse_retune_o != 4'h0 |-> $onehot(coarse_retune_o) || coarse_retune_o == 4'hF;
  endproperty
  a_retune_shape: assert property (p_retune_shape) else $error("retune neither one nor all");
  property p_retune_pulse;
    coarse_retune_o != 4'h0 |=> coarse_retune_o == 4'h0;
  endproperty
  a_retune_pulse: assert property (p_retune_pulse) else $error("retune longer than a cycle");
  property p_hold0;
    link_valid_o[0] && !link_ready_i[0] |=> link_valid_o[0] && $stable(link_word0_o);
  endproperty
  a_hold0: assert property (p_hold0) else $error("link 0 word dropped under stall");
  property p_hold1;
    link_valid_o[1] && !link_ready_i[1] |=> link_valid_o[1] && $stable(link_word1_o);
  endproperty
  a_hold1: assert property (p_hold1) else $error("link 1 word dropped under stall");
  property p_full0;
    !link_accept_o[0] |-> link_valid_o[0];
  endproperty
  a_full0: assert property (p_full0) else $error("link 0 refuses while empty");
  property p_side0;
    link_valid_o[0] && is_zero(sel_q[3:0]) |-> !link_word0_o.side0;
  endproperty
  a_side0: assert property (p_side0) else $error("side bit zero not low");
  property p_side1;
    link_valid_o[0] && is_zero(sel_q[7:4]) |-> !link_word0_o.side1;
  endproperty
  a_side1: assert property (p_side1) else $error("side bit one not low");
  c_all: cover property (coarse_retune_o == 4'hF);
  c_drain: cover property (link_valid_o[0] && link_ready_i[0]);
  c_full: cover property (!link_accept_o[0]);
endmodule : ddc_rate_match_sva
bind ddc_rate_match ddc_rate_match_sva u_sva (.ref_clk_i, .reset_n_i, .hsel, .haddr, .htrans, .hwrite,
  .hwdata, .hready, .hrdata, .link_valid_o, .link_ready_i, .link_accept_o, .link_word0_o, .link_word1_o,
  .coarse_retune_o, .nco_chan_sel_o);
`default_nettype wire

// ---- tb/ddc_rate_match_tb_top.sv ----
// ddc_rate_match_tb_top: register, stream, fifo, hop and side bit tests
// assumes: 20 MHz clock, two sink models stand in for the transmitter
`timescale 1ns/1ps
`default_nettype none
`include "rate_match_params.svh"
module ddc_rate_match_tb_top;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic hsel = 1'b0;
  logic [13:0] haddr = 14'h0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [3:0] cv = 4'h0, ovr = 4'h0, lw = 4'h0, fd = 4'h0;
  logic [63:0] cd = 64'h0;
  logic sysref = 1'b0, hop = 1'b0;
  logic [5:0] prof = 6'h00;
  logic [1:0] stall = 2'h0, slow = 2'h2;
  wire logic hreadyout, hresp;
  wire logic [31:0] hrdata;
  wire logic [3:0] retune, nco;
  wire logic [1:0] lv, lr, acc;
  wire rate_match_pkg::link_word_t w0, w1;
  int n_mismatch = 0;
  int num_checks = 0;
  always #25 clk = ~clk;
  ddc_rate_match dut (.ref_clk_i(clk), .reset_n_i(reset_n), .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .chan_valid_i(cv),
    .chan_data_i(cd), .overrange_i(ovr), .level_watch_flag_i(lw), .fast_threshold_flag_i(fd),
    .sysref_i(sysref), .profile_sel_i(prof), .hop_strobe_i(hop), .coarse_retune_o(retune),
    .nco_chan_sel_o(nco), .link_valid_o(lv), .link_ready_i(lr), .link_word0_o(w0), .link_word1_o(w1),
    .link_accept_o(acc));
  link_sink_model sink0 (.ref_clk_i(clk), .reset_n_i(reset_n), .stall_i(stall[0]), .slow_i(slow[0]),
    .valid_i(lv[0]), .word_i(w0), .ready_o(lr[0]));
  link_sink_model sink1 (.ref_clk_i(clk), .reset_n_i(reset_n), .stall_i(stall[1]), .slow_i(slow[1]),
    .valid_i(lv[1]), .word_i(w1), .ready_o(lr[1]));
  // ************************************************************
  // tasks
  // ************************************************************
  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : finish_test
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask : chk
  // entered just after a rising edge; every wait ends on hreadyout
  task automatic bus(input logic [11:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= {a, 2'b00};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    r = hrdata;
    chk("hresp", 32'h0000_0000, 32'(hresp));
  endtask : bus
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(a, 1'b1, d, r);
  endtask : wr
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] r;
    bus(a, 1'b0, 32'h0000_0000, r);
    chk($sformatf("reg %h", a), e, r);
  endtask : rdc
  task automatic send(input int c, input logic [15:0] s);
    cd[c*16 +: 16] <= s;
    cv[c] <= 1'b1;
    @(posedge clk);
    cv[c] <= 1'b0;
  endtask : send
  // a few idle cycles after the last word catch any surplus repeat
  task automatic take(input bit l, input int n, input logic [19:0] e);
    int k;
    rate_match_pkg::link_word_t q[$];
    k = 0;
    while ((l ? sink1.got_q.size() : sink0.got_q.size()) < n && k < 60) begin
      @(posedge clk);
      k++;
    end
    repeat (6) @(posedge clk);
    if (l)
      q = sink1.got_q;
    else
      q = sink0.got_q;
    chk("word count", 32'(n), 32'(q.size()));
    foreach (q[i]) chk("word", 32'(e), 32'(q[i]));
    sink0.got_q.delete();
    sink1.got_q.delete();
  endtask : take
  task automatic hopt(input logic [3:0] e);
    int k;
    k = 0;
    hop <= 1'b1;
    do begin
      @(posedge clk);
      k++;
    end while (retune == 4'h0 && k < 20);
    hop <= 1'b0;
    chk("retune", 32'(e), 32'(retune));
    repeat (4) @(posedge clk);
  endtask : hopt
  // nco selection holds 0xA here, so its bit k[1:0] equals k[0]
  function automatic logic side_exp(input logic [3:0] k, input bit p);
    case (k)
      4'h0, 4'h3, 4'h5: return !p;
      4'h2: return p;
      4'h8, 4'h9, 4'hA, 4'hB: return k[0];
      default: return 1'b0;
    endcase
  endfunction : side_exp
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    finish_test();
  end
  initial begin
    logic [3:0] k0, k1;
    bit p;
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    rdc(`RM_IDX_LINK_RATE_DIVISOR, 32'h0000_0000);
    rdc(`RM_IDX_JOINT_RETUNE, 32'h0000_0000);
    rdc(`RM_IDX_SIDE_BITS_SEL, 32'h0000_0000);
    wr(12'h0123, 32'h0000_00FF);
    rdc(12'h0123, 32'h0000_0000);
    wr(`RM_IDX_LINK_RATE_DIVISOR, 32'h0000_0010);
    wr(`RM_IDX_PAGE_SELECT, 32'h0000_0001);
    wr(`RM_IDX_LINK_RATE_DIVISOR, 32'h0000_0004);
    rdc(`RM_IDX_LINK_RATE_DIVISOR, 32'h0000_0004);
    wr(`RM_IDX_PAGE_SELECT, 32'h0000_0000);
    rdc(`RM_IDX_LINK_RATE_DIVISOR, 32'h0000_0010);
    wr(`RM_IDX_JOINT_RETUNE, 32'h0000_00FF);
    rdc(`RM_IDX_JOINT_RETUNE, 32'h0000_0001);
    wr(`RM_IDX_JOINT_RETUNE, 32'h0000_0000);
    wr(`RM_IDX_CHAN_TOTAL_DIV0, 32'h0000_0020);
    wr(`RM_IDX_CHAN_TOTAL_DIV0 + 12'h001, 32'h0000_0010);
    wr(`RM_IDX_CHAN_TOTAL_DIV0 + 12'h002, 32'h0000_0040);
    wr(`RM_IDX_CHAN_TOTAL_DIV0 + 12'h003, 32'h0000_0004);
    wr(`RM_IDX_COARSE_DIV0 + 12'h002, 32'h0000_0008);
    wr(`RM_IDX_FINE_BYPASS, 32'h0000_0004);
    wr(`RM_IDX_CHAN_LINK_MAP, 32'h0000_000C);
    ovr <= 4'h5;
    send(0, 16'hA001);
    take(0, 2, {2'h0, 1'b1, 1'b1, 16'hA001});
    send(1, 16'hB002);
    take(0, 1, {2'h1, 1'b0, 1'b0, 16'hB002});
    send(2, 16'hC003);
    take(1, 2, {2'h2, 1'b1, 1'b1, 16'hC003});
    stall <= 2'h1;
    repeat (4) begin
      send(0, 16'hD004);
      repeat (4) @(posedge clk);
    end
    chk("accept", 32'h0000_0000, 32'(acc[0]));
    rdc(`RM_IDX_CHAN_STATUS, 32'h0000_0080);
    slow <= 2'h1;
    stall <= 2'h0;
    take(0, 8, {2'h0, 1'b1, 1'b1, 16'hD004});
    chk("accept", 32'h0000_0001, 32'(acc[0]));
    prof <= 6'h2A;
    wr(`RM_IDX_HOP_CONTROL, 32'h0000_0001);
    hopt(4'h4);
    chk("nco", 32'h0000_000A, 32'(nco));
    wr(`RM_IDX_JOINT_RETUNE, 32'h0000_0001);
    hopt(4'hF);
    for (int i = 0; i < 24; i++) begin
      p = i >= 12;
      k0 = 4'(i % 12);
      k1 = 4'(11 - i % 12);
      ovr <= {4{!p}};
      lw <= {4{p}};
      fd <= {4{!p}};
      sysref <= !p;
      wr(`RM_IDX_SIDE_BITS_SEL, {24'h00_0000, k1, k0});
      send(1, 16'hE005);
      take(0, 1, {2'h1, side_exp(k1, p), side_exp(k0, p), 16'hE005});
    end
    finish_test();
  end
endmodule : ddc_rate_match_tb_top
`default_nettype wire
